/* erar_top.sv */
`timescale 1ns/1ns
// Behaviour
// - One 64-bit address register per record at 0x018 plus 64 times index.
// - An error with an address is captured into its record when recorded.
// - Absent records, or records without addresses, read zero and ignore writes.
// - Bits 63 and 59 encode address space; bit 59 zero without realm support.
// - Bit 62 set means the address-space bits might be wrong.
// - Bit 61 set means the recorded address might be invalid or mismatched.
// - Bit 60 marks a virtual address; then bits 63:61 read 0,1,1.
// - Without the virtual flag, a virtual capture still shows bits 63:61 as 0,1,1.
// - The three trust flags are read-only or read/write by build choice.
// - Bits 55:0 hold the address; missing high bits read zero or fixed.
// - Missing low address bits read as zero.
// - Register contents after cold reset are undefined to software.
// - With fault injection, injection-valid 0 and status-valid 1 make it read-only.
// - Without fault injection, status-valid 1 makes it read-only.
// - Otherwise the register is readable and writable.
// - Node features come from the node's first record.
module erar_top import erar_pkg::*; #(
    parameter int unsigned NUM_REC = 4,
    parameter int unsigned RECS_PER_NODE = 1,
    parameter bit REALM = 1'b1,
    parameter bit VA_IMPL = 1'b1,
    parameter bit FLAGS_RW = 1'b1,
    parameter int unsigned PA_BITS = 56,
    parameter int unsigned LOW_BITS = 0,
    parameter logic [LOC_W-1:0] HIGH_FIXED = 56'h0,
    parameter logic [NUM_REC-1:0] REC_PRESENT_MASK = '1,
    parameter logic [NUM_REC-1:0] NODE_INJECT_MASK = '0,
    localparam int unsigned IDX_W = (NUM_REC > 1) ? $clog2(NUM_REC) : 1
) (
    input wire logic clk_in, // 20 MHz clock
    input wire logic nrst_in, // Async reset, active low
    input wire logic acc_req_in, // Register access request
    input wire logic acc_write_in, // 1 write, 0 read
    input wire logic [BUS_ADDR_W-1:0] acc_addr_in, // Byte address
    input wire logic [REG_W-1:0] acc_wdata_in, // Write data
    output logic acc_ack_out, // Access done
    output logic [REG_W-1:0] acc_rdata_out, // Read data
    output logic acc_refused_out, // Write was ignored
    input wire logic err_valid_in, // Error with address recorded
    input wire logic [IDX_W-1:0] err_record_in, // Target record
    input wire logic [LOC_W-1:0] err_addr_in, // Recorded location
    input wire logic err_world_low_in, // Space code, low bit
    input wire logic err_world_high_in, // Space code, high bit
    input wire logic err_space_untrusted_in, // Space bits may be wrong
    input wire logic err_addr_untrusted_in, // Location may be wrong
    input wire logic err_virtual_in, // Location is virtual
    input wire logic [NUM_REC-1:0] status_clear_in, // Clear status-valid per record
    input wire logic [NUM_REC-1:0] injection_location_valid_in, // Injection control per record
    output logic [NUM_REC-1:0] status_location_valid_out // Status-valid per record
);

    // Stored fields of every record
    logic [LOC_W-1:0] loc_q [NUM_REC];
    logic [LOC_W-1:0] loc_d [NUM_REC];
    logic [NUM_REC-1:0] world_low_q;
    logic [NUM_REC-1:0] world_low_d;
    logic [NUM_REC-1:0] world_high_q;
    logic [NUM_REC-1:0] world_high_d;
    logic [NUM_REC-1:0] space_untrusted_q;
    logic [NUM_REC-1:0] space_untrusted_d;
    logic [NUM_REC-1:0] addr_untrusted_q;
    logic [NUM_REC-1:0] addr_untrusted_d;
    logic [NUM_REC-1:0] virtual_location_flag_q;
    logic [NUM_REC-1:0] virtual_location_flag_d;
    logic [NUM_REC-1:0] status_location_valid_q;
    logic [NUM_REC-1:0] status_location_valid_d;

    // Bus answer state
    logic ack_q;
    logic ack_d;
    logic [REG_W-1:0] rdata_q;
    logic [REG_W-1:0] rdata_d;
    logic refused_q;
    logic refused_d;

    // Decode and per-record strobes
    logic [BUS_ADDR_W-REC_STRIDE_SHIFT-1:0] acc_idx;
    logic [IDX_W-1:0] acc_sel;
    logic acc_in_range;
    logic err_in_range;
    logic [NUM_REC-1:0] cap_vec;
    logic [NUM_REC-1:0] wr_vec;
    logic [NUM_REC-1:0] lock_vec;
    logic [REG_W-1:0] rec_word [NUM_REC];

    // First record of the node that owns record n
    function automatic int unsigned first_record(input int unsigned n);
        return n - (n % RECS_PER_NODE);
    endfunction

    // Read-only when the captured location must be protected
    function automatic logic write_locked(input int unsigned n, input logic st, input logic inj);
        if (NODE_INJECT_MASK[first_record(n)]) begin
            return st && !inj;
        end
        return st;
    endfunction

    // Record index and offset check shared by reads and writes
    assign acc_idx = acc_addr_in[BUS_ADDR_W-1:REC_STRIDE_SHIFT];
    assign acc_sel = acc_idx[IDX_W-1:0];
    assign acc_in_range = (acc_addr_in[REC_STRIDE_SHIFT-1:0] == REC_OFFSET) && (32'(acc_idx) < NUM_REC);
    assign err_in_range = 32'(err_record_in) < NUM_REC;

    // Strobes: a capture beats a software write to the same record
    always_comb begin
        cap_vec = '0;
        wr_vec = '0;
        lock_vec = '0;
        for (int unsigned n = 0; n < NUM_REC; n++) begin
            lock_vec[n] = write_locked(n, status_location_valid_q[n], injection_location_valid_in[n]);
            cap_vec[n] = err_valid_in && err_in_range && (32'(err_record_in) == n) && REC_PRESENT_MASK[n];
            wr_vec[n] = acc_req_in && acc_write_in && acc_in_range && (32'(acc_sel) == n)
                && REC_PRESENT_MASK[n] && !lock_vec[n] && !cap_vec[n];
        end
    end

    // Next field values for all records
    always_comb begin
        for (int unsigned n = 0; n < NUM_REC; n++) begin
            loc_d[n] = loc_q[n];
            world_low_d[n] = world_low_q[n];
            world_high_d[n] = world_high_q[n];
            space_untrusted_d[n] = space_untrusted_q[n];
            addr_untrusted_d[n] = addr_untrusted_q[n];
            virtual_location_flag_d[n] = virtual_location_flag_q[n];
            if (cap_vec[n]) begin
                loc_d[n] = err_addr_in;
                world_low_d[n] = err_world_low_in;
                world_high_d[n] = REALM ? err_world_high_in : 1'b0;
                space_untrusted_d[n] = err_space_untrusted_in;
                addr_untrusted_d[n] = err_addr_untrusted_in;
                virtual_location_flag_d[n] = VA_IMPL ? err_virtual_in : 1'b0;
                if (err_virtual_in) begin
                    // Stored forced so the view holds even with no flag to show it
                    world_low_d[n] = 1'b0;
                    space_untrusted_d[n] = 1'b1;
                    addr_untrusted_d[n] = 1'b1;
                end
            end else if (wr_vec[n]) begin
                // Reserved bits 58:56 are simply not stored
                loc_d[n] = acc_wdata_in[LOC_MSB:0];
                world_low_d[n] = acc_wdata_in[BIT_WORLD_LOW];
                world_high_d[n] = REALM ? acc_wdata_in[BIT_WORLD_HIGH] : 1'b0;
                if (FLAGS_RW) begin
                    space_untrusted_d[n] = acc_wdata_in[BIT_SPACE_UNTRUSTED];
                    addr_untrusted_d[n] = acc_wdata_in[BIT_ADDR_UNTRUSTED];
                    virtual_location_flag_d[n] = VA_IMPL ? acc_wdata_in[BIT_VIRTUAL] : 1'b0;
                end
            end
        end
    end

    // Status-valid: a capture in the same cycle as a clear wins
    always_comb begin
        for (int unsigned n = 0; n < NUM_REC; n++) begin
            status_location_valid_d[n] = REC_PRESENT_MASK[n]
                && (cap_vec[n] || (status_location_valid_q[n] && !status_clear_in[n]));
        end
    end

    // Bus answer one cycle after every request; read data holds until the next read
    always_comb begin
        ack_d = acc_req_in;
        rdata_d = rdata_q;
        refused_d = 1'b0;
        if (acc_req_in) begin
            if (!acc_write_in) begin
                // Unmapped offsets and absent records read as zero
                rdata_d = acc_in_range ? rec_word[acc_sel] : REG_RESET;
            end else begin
                refused_d = !(|wr_vec);
            end
        end
    end

    // Read views, one per record
    for (genvar g = 0; g < NUM_REC; g++) begin : g_view
        erar_view_if vif ();

        assign vif.present = REC_PRESENT_MASK[g];
        assign vif.location = loc_q[g];
        assign vif.world_low = world_low_q[g];
        assign vif.world_high = world_high_q[g];
        assign vif.space_untrusted = space_untrusted_q[g];
        assign vif.addr_untrusted = addr_untrusted_q[g];
        assign vif.virtual_flag = virtual_location_flag_q[g];
        assign rec_word[g] = vif.word;

        erar_view #(
            .REALM(REALM),
            .VA_IMPL(VA_IMPL),
            .PA_BITS(PA_BITS),
            .LOW_BITS(LOW_BITS),
            .HIGH_FIXED(HIGH_FIXED)
        ) u_view (
            .link_io(vif.view)
        );
    end

    // Record storage; zero at reset is one legal undefined value, software may not rely on it
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            for (int unsigned n = 0; n < NUM_REC; n++) begin
                loc_q[n] <= '0;
            end
            world_low_q <= '0;
            world_high_q <= '0;
            space_untrusted_q <= '0;
            addr_untrusted_q <= '0;
            virtual_location_flag_q <= '0;
        end else begin
            for (int unsigned n = 0; n < NUM_REC; n++) begin
                loc_q[n] <= loc_d[n];
            end
            world_low_q <= world_low_d;
            world_high_q <= world_high_d;
            space_untrusted_q <= space_untrusted_d;
            addr_untrusted_q <= addr_untrusted_d;
            virtual_location_flag_q <= virtual_location_flag_d;
        end
    end

    // Status-valid flags
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            status_location_valid_q <= '0;
        end else begin
            status_location_valid_q <= status_location_valid_d;
        end
    end

    // Bus answer registers
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ack_q <= 1'b0;
            rdata_q <= REG_RESET;
            refused_q <= 1'b0;
        end else begin
            ack_q <= ack_d;
            rdata_q <= rdata_d;
            refused_q <= refused_d;
        end
    end

    // Outputs straight from flip-flops
    assign acc_ack_out = ack_q;
    assign acc_rdata_out = rdata_q;
    assign acc_refused_out = refused_q;
    assign status_location_valid_out = status_location_valid_q;

endmodule

/* erar_pkg.sv */
package erar_pkg;

    // Record placement on the memory-mapped interface
    localparam int unsigned MAX_RECORDS = 65535;
    localparam logic [5:0] REC_OFFSET = 6'h18;
    localparam int unsigned REC_STRIDE_BYTES = 64;
    localparam int unsigned REC_STRIDE_SHIFT = $clog2(REC_STRIDE_BYTES);
    localparam int unsigned BUS_ADDR_W = 22;
    localparam int unsigned REG_W = 64;

    // Field positions of the address register
    localparam int unsigned BIT_WORLD_LOW = 63;
    localparam int unsigned BIT_SPACE_UNTRUSTED = 62;
    localparam int unsigned BIT_ADDR_UNTRUSTED = 61;
    localparam int unsigned BIT_VIRTUAL = 60;
    localparam int unsigned BIT_WORLD_HIGH = 59;
    localparam int unsigned RSV_MSB = 58;
    localparam int unsigned RSV_LSB = 56;
    localparam int unsigned LOC_MSB = 55;
    localparam int unsigned LOC_W = 56;

    // Reset and forced values
    localparam logic [63:0] REG_RESET = 64'h0;
    localparam logic [2:0] VIRTUAL_FORCED = 3'h3;
    localparam int unsigned ACK_LATENCY = 1;

    // Address space code, {world_high, world_low}
    typedef enum logic [1:0] {
        WORLD_SECURE = 2'h0,
        WORLD_NONSECURE = 2'h1,
        WORLD_ROOT = 2'h2,
        WORLD_REALM = 2'h3
    } erar_world_type;

    // Location bits that exist: [pa_bits-1:low_bits]
    function automatic logic [LOC_W-1:0] erar_loc_mask(input int unsigned pa_bits, input int unsigned low_bits);
        logic [LOC_W-1:0] m;
        m = '0;
        for (int i = 0; i < LOC_W; i++) begin
            if ((i < pa_bits) && (i >= low_bits)) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction

    // Location bits above the implemented physical size
    function automatic logic [LOC_W-1:0] erar_high_mask(input int unsigned pa_bits);
        logic [LOC_W-1:0] m;
        m = '0;
        for (int i = 0; i < LOC_W; i++) begin
            if (i >= pa_bits) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction

endpackage

/* erar_view_if.sv */
`timescale 1ns/1ns
interface erar_view_if import erar_pkg::*; ();
    logic present;
    logic [LOC_W-1:0] location;
    logic world_low;
    logic world_high;
    logic space_untrusted;
    logic addr_untrusted;
    logic virtual_flag;
    logic [REG_W-1:0] word;

    modport store (
        output present, location, world_low, world_high, space_untrusted, addr_untrusted, virtual_flag,
        input word
    );
    modport view (
        input present, location, world_low, world_high, space_untrusted, addr_untrusted, virtual_flag,
        output word
    );
endinterface

/* erar_view.sv */
`timescale 1ns/1ns
module erar_view import erar_pkg::*; #(
    parameter bit REALM = 1'b1,
    parameter bit VA_IMPL = 1'b1,
    parameter int unsigned PA_BITS = 56,
    parameter int unsigned LOW_BITS = 0,
    parameter logic [LOC_W-1:0] HIGH_FIXED = 56'h0
) (
    erar_view_if.view link_io // Stored fields in, read word out
);
    localparam logic [LOC_W-1:0] LOC_MASK = erar_loc_mask(PA_BITS, LOW_BITS);
    localparam logic [LOC_W-1:0] HIGH_MASK = erar_high_mask(PA_BITS);

    // Software view of one record, built purely from stored state
    always_comb begin
        link_io.word = REG_RESET;
        if (link_io.present) begin
            // Missing low bits read zero, missing high bits read the fixed value
            link_io.word[LOC_MSB:0] = (link_io.location & LOC_MASK) | (HIGH_FIXED & HIGH_MASK);
            link_io.word[RSV_MSB:RSV_LSB] = 3'h0;
            link_io.word[BIT_WORLD_HIGH] = REALM ? link_io.world_high : 1'b0;
            link_io.word[BIT_WORLD_LOW] = link_io.world_low;
            link_io.word[BIT_SPACE_UNTRUSTED] = link_io.space_untrusted;
            link_io.word[BIT_ADDR_UNTRUSTED] = link_io.addr_untrusted;
            if (VA_IMPL && link_io.virtual_flag) begin
                // No context for a virtual location, so the attributes are meaningless
                link_io.word[BIT_VIRTUAL] = 1'b1;
                link_io.word[BIT_WORLD_LOW:BIT_ADDR_UNTRUSTED] = VIRTUAL_FORCED;
            end
        end
    end

endmodule

/* erar_top_chk.sv */
`timescale 1ns/1ns
module erar_top_chk import erar_pkg::*; #(
    parameter int unsigned NUM_REC = 4,
    parameter logic [NUM_REC-1:0] REC_PRESENT_MASK = '1,
    parameter logic [NUM_REC-1:0] NODE_INJECT_MASK = '0,
    localparam int unsigned IDX_W = (NUM_REC > 1) ? $clog2(NUM_REC) : 1
) (
    input wire logic clk_in, // Clock
    input wire logic nrst_in, // Reset, active low
    input wire logic acc_req_in, // Access request
    input wire logic acc_write_in, // Write select
    input wire logic [BUS_ADDR_W-1:0] acc_addr_in, // Byte address
    input wire logic acc_ack_out, // Access done
    input wire logic [REG_W-1:0] acc_rdata_out, // Read data
    input wire logic acc_refused_out, // Write ignored
    input wire logic err_valid_in, // Capture strobe
    input wire logic [IDX_W-1:0] err_record_in, // Capture record
    input wire logic [NUM_REC-1:0] injection_location_valid_in, // Injection control
    input wire logic [NUM_REC-1:0] status_location_valid_out // Status-valid
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);

    // Index field of the access; only meaningful when in range
    logic in_range;
    logic [IDX_W-1:0] idx;
    assign in_range = acc_addr_in[BUS_ADDR_W-1:6] < NUM_REC;
    assign idx = acc_addr_in[6 +: IDX_W];

    sequence s_capture;
        err_valid_in && REC_PRESENT_MASK[err_record_in];
    endsequence
    sequence s_write;
        acc_req_in && acc_write_in;
    endsequence
    sequence s_locked_write;
        s_write ##0 (acc_addr_in == 22'h18) && status_location_valid_out[0] && !NODE_INJECT_MASK[0];
    endsequence
    sequence s_open_write;
        s_write ##0 in_range && acc_addr_in[5:0] == REC_OFFSET && REC_PRESENT_MASK[idx] && NODE_INJECT_MASK[idx]
            && injection_location_valid_in[idx] && !(err_valid_in && err_record_in == idx);
    endsequence

    a_ack_next_edge: assert property (acc_req_in |=> acc_ack_out)
        else $error("ack missing after request");
    a_ack_no_spurious: assert property (!acc_req_in |=> !acc_ack_out)
        else $error("ack without request");
    a_read_not_refused: assert property (acc_req_in && !acc_write_in |=> !acc_refused_out)
        else $error("read reported refused");
    a_offset_write_refused: assert property (s_write ##0 acc_addr_in[5:0] != REC_OFFSET |=> acc_refused_out)
        else $error("write off the register offset accepted");
    a_reserved_reads_zero: assert property (acc_ack_out |-> acc_rdata_out[RSV_MSB:RSV_LSB] == 3'h0)
        else $error("reserved bits not zero");
    a_virtual_forces_flags: assert property (acc_ack_out && acc_rdata_out[BIT_VIRTUAL] |-> acc_rdata_out[63:61] == VIRTUAL_FORCED)
        else $error("virtual word flags wrong");
    a_capture_sets_valid: assert property (s_capture |=> status_location_valid_out[$past(err_record_in)])
        else $error("capture did not set status-valid");
    a_locked_write_refused: assert property (s_locked_write |=> acc_refused_out)
        else $error("write to locked record accepted");
    a_absent_read_zero: assert property (acc_req_in && !acc_write_in && in_range && !REC_PRESENT_MASK[idx] |=> acc_rdata_out == 64'h0)
        else $error("absent record read not zero");
    a_inject_open_write: assert property (s_open_write |=> !acc_refused_out)
        else $error("write refused while injection valid");
endmodule

bind erar_top erar_top_chk #(.NUM_REC(NUM_REC), .REC_PRESENT_MASK(REC_PRESENT_MASK),
    .NODE_INJECT_MASK(NODE_INJECT_MASK)) i_chk (.clk_in(clk_in), .nrst_in(nrst_in), .acc_req_in(acc_req_in),
    .acc_write_in(acc_write_in), .acc_addr_in(acc_addr_in), .acc_ack_out(acc_ack_out),
    .acc_rdata_out(acc_rdata_out), .acc_refused_out(acc_refused_out), .err_valid_in(err_valid_in),
    .err_record_in(err_record_in), .injection_location_valid_in(injection_location_valid_in),
    .status_location_valid_out(status_location_valid_out));

/* erar_top_tb.sv */
`timescale 1ns/1ns
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; $display("mismatch %s expected %h seen %h", nm, e, g); end end
module erar_top_tb import erar_pkg::*;;
    logic clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic acc_req_in = 1'b0;
    logic acc_write_in = 1'b0;
    logic [21:0] acc_addr_in = 22'h0;
    logic [63:0] acc_wdata_in = 64'h0;
    logic acc_ack_out;
    logic [63:0] acc_rdata_out;
    logic acc_refused_out;
    logic err_valid_in = 1'b0;
    logic [1:0] err_record_in = 2'h0;
    logic [55:0] err_addr_in = 56'h0;
    logic [4:0] err_f = 5'h0;
    logic [3:0] status_clear_in = 4'h0;
    logic [3:0] injection_location_valid_in = 4'h0;
    logic [3:0] status_location_valid_out;
    logic alt_ack;
    logic [63:0] alt_rdata;
    logic alt_refused;
    logic [3:0] alt_status;
    logic [63:0] alt_rd;
    logic alt_rf;
    int n_fail = 0;
    int cmp_count = 0;

    // Record 3 absent, record 2 owns fault injection
    erar_top #(.NUM_REC(4), .REC_PRESENT_MASK(4'h7), .NODE_INJECT_MASK(4'h4)) i_dut (
        .clk_in(clk_in), .nrst_in(nrst_in), .acc_req_in(acc_req_in), .acc_write_in(acc_write_in),
        .acc_addr_in(acc_addr_in), .acc_wdata_in(acc_wdata_in), .acc_ack_out(acc_ack_out),
        .acc_rdata_out(acc_rdata_out), .acc_refused_out(acc_refused_out), .err_valid_in(err_valid_in),
        .err_record_in(err_record_in), .err_addr_in(err_addr_in), .err_world_high_in(err_f[4]),
        .err_world_low_in(err_f[3]), .err_space_untrusted_in(err_f[2]), .err_addr_untrusted_in(err_f[1]),
        .err_virtual_in(err_f[0]), .status_clear_in(status_clear_in),
        .injection_location_valid_in(injection_location_valid_in),
        .status_location_valid_out(status_location_valid_out));

    // No realm, no virtual flag, read-only flags, 48-bit space, 16-byte grain; record 0 speaks for the node
    erar_top #(.NUM_REC(4), .RECS_PER_NODE(4), .REALM(1'b0), .VA_IMPL(1'b0), .FLAGS_RW(1'b0), .PA_BITS(48),
        .LOW_BITS(4), .HIGH_FIXED(56'h5a_0000_0000_0000), .REC_PRESENT_MASK(4'h7),
        .NODE_INJECT_MASK(4'h1)) i_dut_alt (
        .clk_in(clk_in), .nrst_in(nrst_in), .acc_req_in(acc_req_in), .acc_write_in(acc_write_in),
        .acc_addr_in(acc_addr_in), .acc_wdata_in(acc_wdata_in), .acc_ack_out(alt_ack),
        .acc_rdata_out(alt_rdata), .acc_refused_out(alt_refused), .err_valid_in(err_valid_in),
        .err_record_in(err_record_in), .err_addr_in(err_addr_in), .err_world_high_in(err_f[4]),
        .err_world_low_in(err_f[3]), .err_space_untrusted_in(err_f[2]), .err_addr_untrusted_in(err_f[1]),
        .err_virtual_in(err_f[0]), .status_clear_in(status_clear_in),
        .injection_location_valid_in(injection_location_valid_in),
        .status_location_valid_out(alt_status));

    always #25 clk_in = ~clk_in;

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // One access; the ack is awaited under a short bound
    task automatic acc(input logic wr, input logic [21:0] a, input logic [63:0] d, output logic [63:0] rd,
        output logic rf);
        int n;
        @(posedge clk_in);
        #1;
        acc_req_in = 1'b1;
        acc_write_in = wr;
        acc_addr_in = a;
        acc_wdata_in = d;
        @(posedge clk_in);
        #1;
        acc_req_in = 1'b0;
        n = 0;
        while (acc_ack_out !== 1'b1 && n < 4) begin
            @(posedge clk_in);
            #1;
            n++;
        end
        if (acc_ack_out !== 1'b1) begin
            n_fail++;
            $display("mismatch acc_ack_out expected 1 seen 0");
            tally_and_finish();
        end
        rd = acc_rdata_out;
        rf = acc_refused_out;
        alt_rd = alt_rdata;
        alt_rf = alt_refused;
        `CHK("alt_ack", 1'b1, alt_ack)
    endtask

    task automatic rd_chk(input string nm, input logic [21:0] a, input logic [63:0] e);
        logic [63:0] rd;
        logic rf;
        acc(1'b0, a, 64'h0, rd, rf);
        `CHK(nm, e, rd)
    endtask

    task automatic wr_chk(input logic [21:0] a, input logic [63:0] d, input logic e_ref);
        logic [63:0] rd;
        logic rf;
        acc(1'b1, a, d, rd, rf);
        `CHK("acc_refused_out", e_ref, rf)
        `CHK("alt_refused", e_ref, alt_rf)
    endtask

    // Flags are {world_high, world_low, space_untrusted, addr_untrusted, virtual}
    task automatic capture(input logic [1:0] rec, input logic [55:0] loc, input logic [4:0] f);
        @(posedge clk_in);
        #1;
        err_valid_in = 1'b1;
        err_record_in = rec;
        err_addr_in = loc;
        err_f = f;
        @(posedge clk_in);
        #1;
        err_valid_in = 1'b0;
    endtask

    // Every space code captured into record 1
    task automatic s_world();
        logic [1:0] w;
        for (int i = 0; i < 4; i++) begin
            w = 2'(i);
            capture(2'h1, 56'h12_3456_789a_bcde + 56'(i), {w[1], w[0], 3'h0});
            `CHK("status_valid_1", 1'b1, status_location_valid_out[1])
            rd_chk("world_word", 22'h58, {w[0], 3'h0, w[1], 3'h0, 56'h12_3456_789a_bcde + 56'(i)});
        end
    endtask

    // Locked record ignores writes until status-valid is cleared
    task automatic s_lock();
        wr_chk(22'h58, 64'h0, 1'b1);
        rd_chk("locked_word", 22'h58, 64'h8812_3456_789a_bce1);
        status_clear_in = 4'h2;
        @(posedge clk_in);
        #1;
        status_clear_in = 4'h0;
        `CHK("status_valid_1", 1'b0, status_location_valid_out[1])
        wr_chk(22'h58, 64'h4f00_0000_0000_1234, 1'b0);
        rd_chk("open_word", 22'h58, 64'h4800_0000_0000_1234);
        `CHK("alt_open_word", 64'h005a_0000_0000_1230, alt_rd)
    endtask

    task automatic s_virt();
        capture(2'h0, 56'h00_00ab_cdef_0123, 5'h09);
        rd_chk("virtual_word", 22'h18, 64'h7000_00ab_cdef_0123);
        `CHK("alt_virtual_word", 64'h605a_00ab_cdef_0120, alt_rd)
        wr_chk(22'h018, 64'h0, 1'b1);
    endtask

    // Absent record and a wrong offset
    task automatic s_absent();
        capture(2'h3, 56'h77, 5'h0);
        `CHK("status_valid_3", 1'b0, status_location_valid_out[3])
        wr_chk(22'h0d8, 64'hffff_ffff_ffff_ffff, 1'b1);
        rd_chk("absent_word", 22'h0d8, 64'h0);
        wr_chk(22'h010, 64'h5, 1'b1);
        rd_chk("offset_word", 22'h010, 64'h0);
    endtask

    // Injection-valid reopens a captured record
    task automatic s_inject();
        capture(2'h2, 56'h55, 5'h0);
        wr_chk(22'h098, 64'h1, 1'b1);
        injection_location_valid_in = 4'h4;
        wr_chk(22'h098, 64'habc, 1'b0);
        rd_chk("inject_word", 22'h098, 64'habc);
        `CHK("alt_inject_word", 64'h005a_0000_0000_0ab0, alt_rd)
        `CHK("alt_status", 4'h5, alt_status)
    endtask

    initial begin
        repeat (4) @(posedge clk_in);
        #1;
        nrst_in = 1'b1;
        s_world();
        s_lock();
        s_virt();
        s_absent();
        s_inject();
        tally_and_finish();
    end
endmodule
